// ---- shared/csf_consts.svh ----
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// ==================================================
// register indexes (byte address is four times the index)
`define CSF_IDX_INDIRECT_WIN 5'h00
`define CSF_IDX_T0_CNT     5'h01
`define CSF_IDX_PC_LO      5'h02
`define CSF_IDX_STATUS     5'h03
`define CSF_IDX_PTR        5'h04
`define CSF_IDX_PORT_A     5'h05
`define CSF_IDX_PORT_B     5'h06
`define CSF_IDX_PORT_C     5'h07
`define CSF_IDX_PORT_D     5'h08
`define CSF_IDX_PORT_E     5'h09
`define CSF_IDX_PC_HI_BUF  5'h0A
`define CSF_IDX_INTCTL     5'h0B
`define CSF_IDX_PIRQ       5'h0C
`define CSF_IDX_T1_CNT_LO  5'h0E
`define CSF_IDX_T1_CNT_HI  5'h0F
`define CSF_IDX_T1CTL      5'h10
`define CSF_IDX_T2_CNT     5'h11
`define CSF_IDX_T2CTL      5'h12
`define CSF_IDX_SBUF       5'h13
`define CSF_IDX_SCTL       5'h14
`define CSF_IDX_CCL        5'h15
`define CSF_IDX_CCH        5'h16
`define CSF_IDX_CCCTL      5'h17
`define CSF_IDX_CONV_RES   5'h1E
`define CSF_IDX_CONV_CTLA  5'h1F

// ==================================================
// implemented-bit masks
`define CSF_MASK_ALL       8'hFF
`define CSF_MASK_LOW6      8'h3F
`define CSF_MASK_LOW5      8'h1F
`define CSF_MASK_LOW7      8'h7F
`define CSF_MASK_PIRQ      8'hCF
`define CSF_MASK_STATUS    8'hE7
`define CSF_MASK_NONE      8'h00

// ==================================================
// bits kept across non-power-on resets
`define CSF_KEEP_ALL       8'hFF
`define CSF_KEEP_LOW6      8'h3F
`define CSF_KEEP_BIT0      8'h01
`define CSF_KEEP_STATUS    8'h07
`define CSF_KEEP_NONE      8'h00

// ==================================================
// reset values and fields
`define CSF_RST_ZERO       8'h00
`define CSF_TOPD_POR       2'h3
`define CSF_STATUS_TOPD_LO 3
`define CSF_PORT_A_DIG_MASK 6'h10

`endif

// ---- shared/csf_pkg.sv ----
// ==================================================
// shared types
package csf_pkg;

    // one register write, decoded from the bus
    typedef struct packed {
        logic       we;
        logic [4:0] idx;
        logic [7:0] wdata;
    } csf_wr_t;

    // core registers seen by the cpu datapath
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] pc_low;
        logic [7:0] pc_high_buf;
        logic [7:0] ptr;
        logic [7:0] intctl;
        logic [7:0] pirq;
    } csf_core_view_t;

endpackage

// ---- test/csf_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// register bank checker
module csf_assertions
    import csf_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // pins and latches
    input wire logic [5:0]  port_a_pins,
    input wire logic [7:0]  port_b_pins,
    input wire logic [5:0]  port_a_latch,
    input wire logic [7:0]  port_d_latch
);
    // decoded request fields
    wire logic [4:0] idx   = paddr[6:2];
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic       ok    = !paddr[7] && paddr[1:0] == 2'b00;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // request phases
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd; psel && !penable && !pwrite && ok; endsequence
    sequence s_wr; pready && pwrite && ok; endsequence

    AST_ZERO_WAIT: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_GAP_ZERO: assert property (s_rd ##0 (idx == 5'h00 || idx == 5'h0D
        || (idx >= 5'h18 && idx <= 5'h1D)) |=> prdata == 32'h0)
        else $error("gap location read nonzero");
    AST_CONV_ZERO: assert property (s_rd ##0 (!HAS_CONVERTER && idx >= 5'h1E)
        |=> prdata == 32'h0)
        else $error("converter register read nonzero");
    AST_PORT_A_RD: assert property (s_rd ##0 idx == 5'h05 |=> prdata[7:0] ==
        {2'b00, $past(port_a_pins) & (HAS_CONVERTER ? 6'h10 : 6'h3F)})
        else $error("port a read wrong");
    AST_PORT_B_RD: assert property (s_rd ##0 idx == 5'h06
        |=> prdata[7:0] == $past(port_b_pins))
        else $error("port b read not pins");
    AST_PORT_D_WR: assert property (s_wr ##0 idx == 5'h08
        |=> port_d_latch == $past(wbyte))
        else $error("port d latch not written");
    AST_LATCH_HOLD: assert property (presetn && $past(presetn)
        && !(pready && pwrite && ok && idx == 5'h05) |=> $stable(port_a_latch))
        else $error("port a latch changed without write");
endmodule

`default_nettype wire

// ---- test/csf_core_sfr_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// bench top
module csf_core_sfr_tb
    import csf_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic power_on_reset = 1'b1;
    logic [1:0] warm_reset_to_pd = 2'b00;
    logic psel, penable, pwrite, pready, pslverr, pslverr2;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata, prdata2;
    logic [5:0] port_a_pins = 6'h00, port_c_pins = 6'h00, port_a_latch, port_c_latch, la2;
    logic [7:0] port_b_pins = 8'h00, port_d_pins = 8'h00, port_e_pins = 8'h00;
    logic [7:0] port_b_latch, port_d_latch;
    csf_core_view_t core_view;
    logic [7:0] mdl [32];
    int seed = 56908;
    int n_mismatch = 0;
    int comparisons = 0;
    // writable bits, bits kept on warm reset
    localparam logic [7:0] WM [32] = '{8'h00, 8'hFF, 8'hFF, 8'hE7, 8'hFF, 8'h3F, 8'hFF,
        8'h3F, 8'hFF, 8'h00, 8'h1F, 8'hFF, 8'h8F, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h7F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'hFD};
    localparam logic [7:0] KP [32] = '{8'h00, 8'hFF, 8'h00, 8'h07, 8'hFF, 8'h3F, 8'hFF,
        8'h3F, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h00,
        8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'h00};

    // 50 MHz clock
    always #10 pclk = ~pclk;

    csf_cpu_model u_cpu (.*);
    csf_core_sfr DUT (.*);
    csf_core_sfr #(.HAS_CONVERTER(1'b0)) DUT2 (.*, .prdata(prdata2), .pready(),
        .pslverr(pslverr2), .port_a_latch(la2), .port_b_latch(), .port_c_latch(),
        .port_d_latch(), .core_view());

    // compare and count
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // expected read value of one index
    function automatic logic [31:0] exp_rd(input int i, input bit cv);
        logic [7:0] v;
        v = mdl[i];
        case (i)
            5: v = {2'b00, port_a_pins & (cv ? 6'h10 : 6'h3F)};
            6: v = port_b_pins;
            7: v = {2'b00, port_c_pins};
            8: v = port_d_pins;
            9: v = port_e_pins;
            30, 31: v = cv ? mdl[i] : 8'h00;
            default: ;
        endcase
        return {24'h0, v};
    endfunction

    // reset with model update
    task automatic do_reset(input bit por, input logic [1:0] tpd);
        presetn <= 1'b0;
        power_on_reset <= por;
        warm_reset_to_pd <= tpd;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        foreach (mdl[i]) mdl[i] = por ? 8'h00 : mdl[i] & KP[i];
        mdl[3][4:3] = por ? 2'b11 : tpd;
    endtask

    // read every index on both variants
    task automatic sweep();
        for (int i = 0; i < 32; i++) begin
            u_cpu.xfer(1'b0, 8'(i * 4), 8'h00);
            check("read", prdata, exp_rd(i, 1'b1));
            check("read_nc", prdata2, exp_rd(i, 1'b0));
        end
        check("view", core_view, {mdl[3], mdl[2], mdl[10], mdl[4], mdl[11], mdl[12]});
        check("latch", {port_a_latch, port_b_latch, port_c_latch, port_d_latch, la2},
            {mdl[5][5:0], mdl[6], mdl[7][5:0], mdl[8], mdl[5][5:0]});
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset(1'b1, 2'b00);
        sweep();
        repeat (3) begin
            @(posedge pclk);
            port_a_pins <= 6'($random(seed));
            port_b_pins <= 8'($random(seed));
            port_c_pins <= 6'($random(seed));
            port_d_pins <= 8'($random(seed));
            port_e_pins <= 8'($random(seed));
            for (int i = 0; i < 32; i++) begin
                d = 8'($random(seed));
                u_cpu.xfer(1'b1, 8'(i * 4), d);
                mdl[i] = (mdl[i] & ~WM[i]) | (d & WM[i]);
            end
            sweep();
        end
        do_reset(1'b0, 2'b01);
        sweep();
        u_cpu.xfer(1'b1, 8'h95, 8'hA5);
        check("err_wr", pslverr, 1'b1);
        u_cpu.xfer(1'b0, 8'h16, 8'h00);
        check("err_rd", {pslverr, prdata}, {1'b1, 32'h0});
        check("err_rd_nc", {pslverr2, prdata2}, {1'b1, 32'h0});
        sweep();
        summarize();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
endmodule

bind csf_core_sfr csf_assertions #(.HAS_CONVERTER(HAS_CONVERTER)) u_chk (.*);

`default_nettype wire

// ---- test/csf_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// cpu data access path, apb master
module csf_cpu_model (
    // clock
    input wire logic         pclk,
    // apb
    output var logic         psel,
    output var logic         penable,
    output var logic         pwrite,
    output var logic [7:0]   paddr,
    output var logic [31:0]  pwdata,
    input wire logic         pready
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer, held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] sd;
        sd = d;
        if (a[6:2] == 5'h0C) sd[6] = 1'b0;
        if (a[6:2] == 5'h1F) sd[1] = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, sd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- verilog/csf_apb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.svh"

// ==================================================
// apb slave: zero-wait access phase, registered answer
module csf_apb_slave
    import csf_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register side
    output logic      [4:0]  rd_idx,
    input  wire logic [7:0]  rd_data,
    output csf_wr_t          wr
);

    logic addr_err;

    // index decode; above the bank or unaligned is an error
    assign rd_idx   = paddr[6:2];
    assign addr_err = paddr[7] | (paddr[1:0] != 2'h0);

    // write commits at the completing edge only
    assign wr.we    = psel & penable & pready & pwrite & ~addr_err;
    assign wr.idx   = paddr[6:2];
    assign wr.wdata = pwdata[7:0];

    // answer captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= addr_err;
                prdata  <= (addr_err || pwrite) ? 32'h0000_0000 : {24'h00_0000, rd_data};
            end
        end
    end

endmodule
`default_nettype wire

// ---- verilog/csf_core_sfr.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.svh"

// Contract
// - registers are static storage, cpu read/write
// - gap locations read zero, ignore writes
// - unimplemented bits inside registers read zero
// - no converter: converter registers read zero
// - converter variant: port a reads 000x 0000, only pin bit 4 live
// - both variants: port a kept on warm reset

// ==================================================
// bank-0 special function register file
module csf_core_sfr
    import csf_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // reset cause, held through the first edge after release
    input  wire logic        power_on_reset,
    input  wire logic [1:0]  warm_reset_to_pd,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sensed pin levels
    input  wire logic [5:0]  port_a_pins,
    input  wire logic [7:0]  port_b_pins,
    input  wire logic [5:0]  port_c_pins,
    input  wire logic [7:0]  port_d_pins,
    input  wire logic [7:0]  port_e_pins,
    // output latches
    output logic      [5:0]  port_a_latch,
    output logic      [7:0]  port_b_latch,
    output logic      [5:0]  port_c_latch,
    output logic      [7:0]  port_d_latch,
    // core registers for the cpu
    output csf_core_view_t   core_view
);

    // ==================================================
    // internal signals
    csf_wr_t    wr;
    logic [4:0] rd_idx;
    logic [7:0] rd_data;
    logic       init_pend;
    logic [1:0] to_pd;
    logic [7:0] q_t0_count;
    logic [7:0] q_pc_low;
    logic [7:0] q_status;
    logic [7:0] q_ptr;
    logic [7:0] q_port_a;
    logic [7:0] q_port_b;
    logic [7:0] q_port_c;
    logic [7:0] q_port_d;
    logic [7:0] q_pc_high_buf;
    logic [7:0] q_intctl;
    logic [7:0] q_pirq;
    logic [7:0] q_t1_cnt_lo;
    logic [7:0] q_t1_cnt_hi;
    logic [7:0] q_t1ctl;
    logic [7:0] q_t2_cnt;
    logic [7:0] q_t2ctl;
    logic [7:0] q_sbuf;
    logic [7:0] q_sctl;
    logic [7:0] q_ccl;
    logic [7:0] q_cch;
    logic [7:0] q_ccctl;
    logic [7:0] q_conv_res;
    logic [7:0] q_conv_ctla;
    logic [5:0] port_a_read;
    logic       conv_we;

    // ==================================================
    // bus slave
    csf_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .wr      (wr)
    );

    // ==================================================
    // reset kind
    // one-cycle load window right after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_pend <= 1'b1;
        end else begin
            init_pend <= 1'b0;
        end
    end

    // time-out and power-down status, read-only to software
    always_ff @(posedge pclk) begin
        if (init_pend) begin
            to_pd <= power_on_reset ? `CSF_TOPD_POR : warm_reset_to_pd;
        end
    end

    // converter registers absent on the plain variant
    assign conv_we = HAS_CONVERTER & wr.we;

    // ==================================================
    // register cells
    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_t0_count (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T0_CNT),
        .wdata   (wr.wdata),
        .q       (q_t0_count)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_NONE)) u_pc_low (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PC_LO),
        .wdata   (wr.wdata),
        .q       (q_pc_low)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_STATUS), .KEEP(`CSF_KEEP_STATUS)) u_status (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_STATUS),
        .wdata   (wr.wdata),
        .q       (q_status)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_ptr (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PTR),
        .wdata   (wr.wdata),
        .q       (q_ptr)
    );

    // port a latch kept over warm resets
    csf_sfr_byte #(.MASK(`CSF_MASK_LOW6), .KEEP(`CSF_KEEP_LOW6)) u_port_a (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PORT_A),
        .wdata   (wr.wdata),
        .q       (q_port_a)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_port_b (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PORT_B),
        .wdata   (wr.wdata),
        .q       (q_port_b)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_LOW6), .KEEP(`CSF_KEEP_LOW6)) u_port_c (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PORT_C),
        .wdata   (wr.wdata),
        .q       (q_port_c)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_NONE)) u_port_d (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PORT_D),
        .wdata   (wr.wdata),
        .q       (q_port_d)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_LOW5), .KEEP(`CSF_KEEP_NONE)) u_pc_high_buf (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PC_HI_BUF),
        .wdata   (wr.wdata),
        .q       (q_pc_high_buf)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_BIT0)) u_intctl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_INTCTL),
        .wdata   (wr.wdata),
        .q       (q_intctl)
    );

    // converter_done_flag position is stored; software keeps it clear
    csf_sfr_byte #(.MASK(`CSF_MASK_PIRQ), .KEEP(`CSF_KEEP_NONE)) u_pirq (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_PIRQ),
        .wdata   (wr.wdata),
        .q       (q_pirq)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_t1_cnt_lo (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T1_CNT_LO),
        .wdata   (wr.wdata),
        .q       (q_t1_cnt_lo)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_t1_cnt_hi (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T1_CNT_HI),
        .wdata   (wr.wdata),
        .q       (q_t1_cnt_hi)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_LOW6), .KEEP(`CSF_KEEP_LOW6)) u_t1ctl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T1CTL),
        .wdata   (wr.wdata),
        .q       (q_t1ctl)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_NONE)) u_t2_cnt (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T2_CNT),
        .wdata   (wr.wdata),
        .q       (q_t2_cnt)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_LOW7), .KEEP(`CSF_KEEP_NONE)) u_t2ctl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_T2CTL),
        .wdata   (wr.wdata),
        .q       (q_t2ctl)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_sbuf (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_SBUF),
        .wdata   (wr.wdata),
        .q       (q_sbuf)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_NONE)) u_sctl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_SCTL),
        .wdata   (wr.wdata),
        .q       (q_sctl)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_ccl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_CCL),
        .wdata   (wr.wdata),
        .q       (q_ccl)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_cch (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_CCH),
        .wdata   (wr.wdata),
        .q       (q_cch)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_LOW6), .KEEP(`CSF_KEEP_NONE)) u_ccctl (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (wr.we && wr.idx == `CSF_IDX_CCCTL),
        .wdata   (wr.wdata),
        .q       (q_ccctl)
    );

    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_ALL)) u_conv_res (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (conv_we && wr.idx == `CSF_IDX_CONV_RES),
        .wdata   (wr.wdata),
        .q       (q_conv_res)
    );

    // bit1 stored as written; software keeps it clear
    csf_sfr_byte #(.MASK(`CSF_MASK_ALL), .KEEP(`CSF_KEEP_NONE)) u_conv_ctla (
        .pclk (pclk), .presetn (presetn), .init (init_pend), .por (power_on_reset),
        .we      (conv_we && wr.idx == `CSF_IDX_CONV_CTLA),
        .wdata   (wr.wdata),
        .q       (q_conv_ctla)
    );

    // ==================================================
    // read side
    // converter variant: analog port a pins sense as zero
    assign port_a_read = HAS_CONVERTER ? (port_a_pins & `CSF_PORT_A_DIG_MASK)
                                       : port_a_pins;

    // read mux; gaps and absent registers give zero
    always_comb begin
        rd_data = `CSF_RST_ZERO;
        case (rd_idx)
            `CSF_IDX_INDIRECT_WIN: rd_data = `CSF_RST_ZERO;
            `CSF_IDX_T0_CNT:    rd_data = q_t0_count;
            `CSF_IDX_PC_LO:     rd_data = q_pc_low;
            `CSF_IDX_STATUS:    rd_data = core_view.status;
            `CSF_IDX_PTR:       rd_data = q_ptr;
            `CSF_IDX_PORT_A:    rd_data = {2'h0, port_a_read};
            `CSF_IDX_PORT_B:    rd_data = port_b_pins;
            `CSF_IDX_PORT_C:    rd_data = {2'h0, port_c_pins};
            `CSF_IDX_PORT_D:    rd_data = port_d_pins;
            `CSF_IDX_PORT_E:    rd_data = port_e_pins;
            `CSF_IDX_PC_HI_BUF: rd_data = q_pc_high_buf;
            `CSF_IDX_INTCTL:    rd_data = q_intctl;
            `CSF_IDX_PIRQ:      rd_data = q_pirq;
            `CSF_IDX_T1_CNT_LO: rd_data = q_t1_cnt_lo;
            `CSF_IDX_T1_CNT_HI: rd_data = q_t1_cnt_hi;
            `CSF_IDX_T1CTL:     rd_data = q_t1ctl;
            `CSF_IDX_T2_CNT:    rd_data = q_t2_cnt;
            `CSF_IDX_T2CTL:     rd_data = q_t2ctl;
            `CSF_IDX_SBUF:      rd_data = q_sbuf;
            `CSF_IDX_SCTL:      rd_data = q_sctl;
            `CSF_IDX_CCL:       rd_data = q_ccl;
            `CSF_IDX_CCH:       rd_data = q_cch;
            `CSF_IDX_CCCTL:     rd_data = q_ccctl;
            `CSF_IDX_CONV_RES:  rd_data = HAS_CONVERTER ? q_conv_res : `CSF_RST_ZERO;
            `CSF_IDX_CONV_CTLA: rd_data = HAS_CONVERTER ? q_conv_ctla : `CSF_RST_ZERO;
            default:            rd_data = `CSF_RST_ZERO;
        endcase
    end

    // ==================================================
    // outputs
    // status joins stored bits with the reset-cause pair
    assign core_view.status      = {q_status[7:5], to_pd, q_status[2:0]};

    // remaining core view and port latches
    assign core_view.pc_low      = q_pc_low;
    assign core_view.pc_high_buf = q_pc_high_buf;
    assign core_view.ptr    = q_ptr;
    assign core_view.intctl = q_intctl;
    assign core_view.pirq   = q_pirq;
    assign port_a_latch     = q_port_a[5:0];
    assign port_b_latch     = q_port_b;
    assign port_c_latch     = q_port_c[5:0];
    assign port_d_latch     = q_port_d;

endmodule
`default_nettype wire

// ---- verilog/csf_sfr_byte.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.svh"

// ==================================================
// one byte register: masked, cleared or kept per bit
module csf_sfr_byte
    import csf_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hFF,
    parameter logic [7:0] KEEP = 8'h00
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // reset-kind load
    input  wire logic       init,
    input  wire logic       por,
    // write port
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    // contents
    output logic      [7:0] q
);

    logic [7:0] keep_q;
    logic [7:0] clr_q;

    // kept bits: no async reset, zero after power-on only
    always_ff @(posedge pclk) begin
        if (init && por) begin
            keep_q <= 8'h00;
        end else if (we) begin
            keep_q <= wdata;
        end
    end

    // cleared bits: zeroed by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_q <= 8'h00;
        end else if (we) begin
            clr_q <= wdata;
        end
    end

    // pick per bit; unimplemented bits read zero
    assign q = (keep_q & MASK & KEEP) | (clr_q & MASK & ~KEEP);

endmodule
`default_nettype wire
